// [rtl/break_pkg.sv]
// Overview of operation
// - reserved bits read zero, software writes zero
// - bit 21 set skips channel A identifier check
// - bit 20 set skips channel B identifier check
// - channel A L bus match sets bit 15
// - channel B L bus match sets bit 14
// - channel A I bus match sets bit 13
// - channel B I bus match sets bit 12
// - match flags stay set until zero written
// - bit 11 switches branch tracing on
// - bit 10 picks channel A fetch break timing
// - bit 7 adds data compare to channel B
// - bit 6 picks channel B fetch break timing
// - bit 3 makes channel A precede channel B
// - bit 0 enables channel B execution count break
package break_pkg;

	// ----------------------------------------------------------------
	// register offsets (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_BREAK_CONTROL = 8'h00;
	localparam logic [7:0] OFS_EXEC_COUNT = 8'h04;
	localparam logic [7:0] OFS_ASID_COMPARE_A = 8'h08;
	localparam logic [7:0] OFS_ASID_COMPARE_B = 8'h0c;
	localparam logic [7:0] OFS_IRQ_STATUS = 8'h10;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h14;

	// ----------------------------------------------------------------
	// widths
	// ----------------------------------------------------------------
	localparam int ASID_WIDTH = 8;
	localparam int EXEC_COUNT_WIDTH = 12;
	localparam int IRQ_WIDTH = 5;

	// ----------------------------------------------------------------
	// break_control field positions
	// ----------------------------------------------------------------
	localparam int BIT_ASID_MASK_CHAN_A = 21;
	localparam int BIT_ASID_MASK_CHAN_B = 20;
	localparam int BIT_LBUS_MATCH_FLAG_A = 15;
	localparam int BIT_LBUS_MATCH_FLAG_B = 14;
	localparam int BIT_IBUS_MATCH_FLAG_A = 13;
	localparam int BIT_IBUS_MATCH_FLAG_B = 12;
	localparam int BIT_BRANCH_TRACE_ENABLE = 11;
	localparam int BIT_FETCH_BREAK_AFTER_A = 10;
	localparam int BIT_DATA_COMPARE_ENABLE_B = 7;
	localparam int BIT_FETCH_BREAK_AFTER_B = 6;
	localparam int BIT_SEQUENTIAL_CHANNELS = 3;
	localparam int BIT_EXEC_COUNT_ENABLE_B = 0;

	// ----------------------------------------------------------------
	// interrupt status / mask field positions
	// ----------------------------------------------------------------
	localparam int IRQ_LBUS_A = 0;
	localparam int IRQ_LBUS_B = 1;
	localparam int IRQ_IBUS_A = 2;
	localparam int IRQ_IBUS_B = 3;
	localparam int IRQ_USER_BREAK = 4;

	// ----------------------------------------------------------------
	// reset values and unmapped read value
	// ----------------------------------------------------------------
	localparam logic RESET_CONTROL_BIT = 1'b0;
	localparam logic [ASID_WIDTH-1:0] RESET_ASID_COMPARE = 8'h00;
	localparam logic [EXEC_COUNT_WIDTH-1:0] RESET_EXEC_COUNT = 12'h000;
	localparam logic [IRQ_WIDTH-1:0] RESET_IRQ = 5'h00;
	localparam logic [31:0] READ_UNMAPPED = 32'h0000_0000;

endpackage

// [rtl/break_channel_match.sv]
module break_channel_match (
	input wire logic [break_pkg::ASID_WIDTH-1:0] asidCompare,
	input wire logic asidMask,
	input wire logic [break_pkg::ASID_WIDTH-1:0] currentAsid,
	input wire logic conditionHit,
	input wire logic dataCompareEnable,
	input wire logic dataHit,
	output logic channelHit
);

	// ----------------------------------------------------------------
	// qualification of the outside address / cycle hit
	// ----------------------------------------------------------------
	logic asidOk;
	logic dataOk;

	always_comb begin
		asidOk = asidMask || (asidCompare == currentAsid);
		dataOk = !dataCompareEnable || dataHit;
		channelHit = conditionHit && asidOk && dataOk;
	end

endmodule // break_channel_match

// [rtl/exec_count_unit.sv]
module exec_count_unit (
	input wire logic clk,
	input wire logic rst,
	input wire logic load,
	input wire logic [break_pkg::EXEC_COUNT_WIDTH-1:0] loadValue,
	input wire logic countEnable,
	input wire logic conditionHit,
	output logic [break_pkg::EXEC_COUNT_WIDTH-1:0] count,
	output logic fire
);

	typedef struct packed {
		logic [break_pkg::EXEC_COUNT_WIDTH-1:0] count;
	} count_state_s;

	count_state_s state;
	count_state_s next_state;

	localparam logic [break_pkg::EXEC_COUNT_WIDTH-1:0] ONE = 12'h001;
	localparam logic [break_pkg::EXEC_COUNT_WIDTH-1:0] ZERO = 12'h000;

	// ----------------------------------------------------------------
	// count down on each satisfied condition, fire when leaving one
	// ----------------------------------------------------------------
	always_comb begin
		next_state = state;
		fire = countEnable && conditionHit && (state.count == ONE);
		if (load) begin
			next_state.count = loadValue;
		end else if (countEnable && conditionHit && state.count != ZERO) begin
			next_state.count = state.count - ONE;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state.count <= break_pkg::RESET_EXEC_COUNT;
		end else begin
			state <= next_state;
		end
	end

	assign count = state.count;

endmodule // exec_count_unit

// [rtl/break_control_unit.sv]
// The Wishbone slave port and the register offsets are this design's own decisions.
module break_control_unit (
	input wire logic clk,
	input wire logic rst,
	// wishbone classic slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [31:0] dat_i,
	input wire logic [3:0] sel_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// core bus observation
	input wire logic lbusCycle,
	input wire logic ibusCycle,
	input wire logic fetchCycle,
	input wire logic [break_pkg::ASID_WIDTH-1:0] currentAsid,
	input wire logic conditionHitA,
	input wire logic conditionHitB,
	input wire logic dataHitB,
	input wire logic instrDone,
	// results
	output logic userBreak,
	output logic breakAfterExec,
	output logic branchTraceEnable,
	output logic irq
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic ack;
		logic [31:0] rdata;
		logic irq;
		logic userBreak;
		logic breakAfterExec;
		logic asidMaskChanA;
		logic asidMaskChanB;
		logic lbusMatchFlagA;
		logic lbusMatchFlagB;
		logic ibusMatchFlagA;
		logic ibusMatchFlagB;
		logic branchTraceEnable;
		logic fetchBreakAfterA;
		logic fetchBreakAfterB;
		logic dataCompareEnableB;
		logic sequentialChannels;
		logic execCountEnableB;
		logic [break_pkg::ASID_WIDTH-1:0] asidCompareChanA;
		logic [break_pkg::ASID_WIDTH-1:0] asidCompareChanB;
		logic sequenceArmed;
		logic pendingAfterA;
		logic pendingAfterB;
		logic [break_pkg::IRQ_WIDTH-1:0] irqStatus;
		logic [break_pkg::IRQ_WIDTH-1:0] irqMask;
	} ctrl_state_s;

	ctrl_state_s state;
	ctrl_state_s next_state;

	// ----------------------------------------------------------------
	// channel qualification and execution counter
	// ----------------------------------------------------------------
	logic hitA;
	logic hitB;
	logic condB;
	logic countFire;
	logic countLoad;
	logic [break_pkg::EXEC_COUNT_WIDTH-1:0] execCount;
	logic busAccess;
	logic busWrite;
	logic busRead;
	logic [31:0] writeMerged;
	logic [31:0] controlRead;

	break_channel_match chanA (
		.asidCompare(state.asidCompareChanA),
		.asidMask(state.asidMaskChanA),
		.currentAsid(currentAsid),
		.conditionHit(conditionHitA),
		.dataCompareEnable(1'b0),
		.dataHit(1'b0),
		.channelHit(hitA)
	);

	break_channel_match chanB (
		.asidCompare(state.asidCompareChanB),
		.asidMask(state.asidMaskChanB),
		.currentAsid(currentAsid),
		.conditionHit(conditionHitB),
		.dataCompareEnable(state.dataCompareEnableB),
		.dataHit(dataHitB),
		.channelHit(hitB)
	);

	exec_count_unit execCounter (
		.clk(clk),
		.rst(rst),
		.load(countLoad),
		.loadValue(writeMerged[break_pkg::EXEC_COUNT_WIDTH-1:0]),
		.countEnable(state.execCountEnableB),
		.conditionHit(condB),
		.count(execCount),
		.fire(countFire)
	);

	// ----------------------------------------------------------------
	// byte lane merge
	// ----------------------------------------------------------------
	function automatic logic [31:0] mergeBytes(
		input logic [31:0] oldValue,
		input logic [31:0] newValue,
		input logic [3:0] sel
	);
		logic [31:0] result;
		result = oldValue;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				result[i*8 +: 8] = newValue[i*8 +: 8];
			end
		end
		return result;
	endfunction

	// ----------------------------------------------------------------
	// read view of break_control
	// ----------------------------------------------------------------
	always_comb begin
		controlRead = 32'h0000_0000;
		controlRead[break_pkg::BIT_ASID_MASK_CHAN_A] = state.asidMaskChanA;
		controlRead[break_pkg::BIT_ASID_MASK_CHAN_B] = state.asidMaskChanB;
		controlRead[break_pkg::BIT_LBUS_MATCH_FLAG_A] = state.lbusMatchFlagA;
		controlRead[break_pkg::BIT_LBUS_MATCH_FLAG_B] = state.lbusMatchFlagB;
		controlRead[break_pkg::BIT_IBUS_MATCH_FLAG_A] = state.ibusMatchFlagA;
		controlRead[break_pkg::BIT_IBUS_MATCH_FLAG_B] = state.ibusMatchFlagB;
		controlRead[break_pkg::BIT_BRANCH_TRACE_ENABLE] = state.branchTraceEnable;
		controlRead[break_pkg::BIT_FETCH_BREAK_AFTER_A] = state.fetchBreakAfterA;
		controlRead[break_pkg::BIT_DATA_COMPARE_ENABLE_B] = state.dataCompareEnableB;
		controlRead[break_pkg::BIT_FETCH_BREAK_AFTER_B] = state.fetchBreakAfterB;
		controlRead[break_pkg::BIT_SEQUENTIAL_CHANNELS] = state.sequentialChannels;
		controlRead[break_pkg::BIT_EXEC_COUNT_ENABLE_B] = state.execCountEnableB;
	end

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	logic breakA;
	logic breakB;
	logic nowBreak;
	logic laterBreak;
	logic setLbusA;
	logic setLbusB;
	logic setIbusA;
	logic setIbusB;
	logic [break_pkg::IRQ_WIDTH-1:0] irqEvents;

	always_comb begin
		next_state = state;
		busAccess = cyc_i && stb_i;
		// write and read effects happen on the edge where ack is seen high
		busWrite = busAccess && state.ack && we_i;
		busRead = busAccess && state.ack && !we_i;
		countLoad = busWrite && (adr_i == break_pkg::OFS_EXEC_COUNT);
		writeMerged = 32'h0000_0000;
		unique case (adr_i)
			break_pkg::OFS_BREAK_CONTROL: begin
				writeMerged = mergeBytes(controlRead, dat_i, sel_i);
			end
			break_pkg::OFS_EXEC_COUNT: begin
				writeMerged = mergeBytes({20'h00000, execCount}, dat_i, sel_i);
			end
			break_pkg::OFS_ASID_COMPARE_A: begin
				writeMerged = mergeBytes({24'h000000, state.asidCompareChanA}, dat_i, sel_i);
			end
			break_pkg::OFS_ASID_COMPARE_B: begin
				writeMerged = mergeBytes({24'h000000, state.asidCompareChanB}, dat_i, sel_i);
			end
			break_pkg::OFS_IRQ_MASK: begin
				writeMerged = mergeBytes({27'h0000000, state.irqMask}, dat_i, sel_i);
			end
			default: begin
				writeMerged = 32'h0000_0000;
			end
		endcase

		// channel B counts only after a channel A match in sequential mode
		condB = hitB && (!state.sequentialChannels || state.sequenceArmed);
		breakA = hitA && !state.sequentialChannels;
		breakB = condB && (!state.execCountEnableB || countFire);

		setLbusA = hitA && lbusCycle;
		setLbusB = condB && lbusCycle;
		setIbusA = hitA && ibusCycle;
		setIbusB = condB && ibusCycle;

		// sequence arming
		if (!state.sequentialChannels) begin
			next_state.sequenceArmed = 1'b0;
		end else if (hitA) begin
			next_state.sequenceArmed = 1'b1;
		end else if (breakB) begin
			next_state.sequenceArmed = 1'b0;
		end

		// break timing: before execution now, after execution on instrDone
		nowBreak = 1'b0;
		laterBreak = 1'b0;
		if (breakA) begin
			if (fetchCycle && state.fetchBreakAfterA) begin
				next_state.pendingAfterA = 1'b1;
			end else begin
				nowBreak = 1'b1;
			end
		end
		if (breakB) begin
			if (fetchCycle && state.fetchBreakAfterB) begin
				next_state.pendingAfterB = 1'b1;
			end else begin
				nowBreak = 1'b1;
			end
		end
		if (instrDone && (state.pendingAfterA || state.pendingAfterB)) begin
			laterBreak = 1'b1;
			next_state.pendingAfterA = breakA && fetchCycle && state.fetchBreakAfterA;
			next_state.pendingAfterB = breakB && fetchCycle && state.fetchBreakAfterB;
		end
		next_state.userBreak = nowBreak || laterBreak;
		next_state.breakAfterExec = laterBreak && !nowBreak;

		// register writes
		if (busWrite) begin
			unique case (adr_i)
				break_pkg::OFS_BREAK_CONTROL: begin
					next_state.asidMaskChanA = writeMerged[break_pkg::BIT_ASID_MASK_CHAN_A];
					next_state.asidMaskChanB = writeMerged[break_pkg::BIT_ASID_MASK_CHAN_B];
					next_state.branchTraceEnable =
						writeMerged[break_pkg::BIT_BRANCH_TRACE_ENABLE];
					next_state.fetchBreakAfterA = writeMerged[break_pkg::BIT_FETCH_BREAK_AFTER_A];
					next_state.dataCompareEnableB =
						writeMerged[break_pkg::BIT_DATA_COMPARE_ENABLE_B];
					next_state.fetchBreakAfterB = writeMerged[break_pkg::BIT_FETCH_BREAK_AFTER_B];
					next_state.sequentialChannels =
						writeMerged[break_pkg::BIT_SEQUENTIAL_CHANNELS];
					next_state.execCountEnableB =
						writeMerged[break_pkg::BIT_EXEC_COUNT_ENABLE_B];
					// flags: writing one keeps, writing zero clears
					next_state.lbusMatchFlagA = state.lbusMatchFlagA &&
						writeMerged[break_pkg::BIT_LBUS_MATCH_FLAG_A];
					next_state.lbusMatchFlagB = state.lbusMatchFlagB &&
						writeMerged[break_pkg::BIT_LBUS_MATCH_FLAG_B];
					next_state.ibusMatchFlagA = state.ibusMatchFlagA &&
						writeMerged[break_pkg::BIT_IBUS_MATCH_FLAG_A];
					next_state.ibusMatchFlagB = state.ibusMatchFlagB &&
						writeMerged[break_pkg::BIT_IBUS_MATCH_FLAG_B];
				end
				break_pkg::OFS_ASID_COMPARE_A: begin
					next_state.asidCompareChanA = writeMerged[break_pkg::ASID_WIDTH-1:0];
				end
				break_pkg::OFS_ASID_COMPARE_B: begin
					next_state.asidCompareChanB = writeMerged[break_pkg::ASID_WIDTH-1:0];
				end
				break_pkg::OFS_IRQ_MASK: begin
					next_state.irqMask = writeMerged[break_pkg::IRQ_WIDTH-1:0];
				end
				default: begin
				end
			endcase
		end

		// hardware set wins over a same-cycle zero write
		if (setLbusA) begin
			next_state.lbusMatchFlagA = 1'b1;
		end
		if (setLbusB) begin
			next_state.lbusMatchFlagB = 1'b1;
		end
		if (setIbusA) begin
			next_state.ibusMatchFlagA = 1'b1;
		end
		if (setIbusB) begin
			next_state.ibusMatchFlagB = 1'b1;
		end

		// interrupt status: read clears, new events win
		irqEvents = 5'h00;
		irqEvents[break_pkg::IRQ_LBUS_A] = setLbusA;
		irqEvents[break_pkg::IRQ_LBUS_B] = setLbusB;
		irqEvents[break_pkg::IRQ_IBUS_A] = setIbusA;
		irqEvents[break_pkg::IRQ_IBUS_B] = setIbusB;
		irqEvents[break_pkg::IRQ_USER_BREAK] = next_state.userBreak;
		if (busRead && adr_i == break_pkg::OFS_IRQ_STATUS) begin
			// clear only what the read reported, so a late event is kept
			next_state.irqStatus = (state.irqStatus & ~state.rdata[break_pkg::IRQ_WIDTH-1:0]) |
				irqEvents;
		end else begin
			next_state.irqStatus = state.irqStatus | irqEvents;
		end
		next_state.irq = |(next_state.irqStatus & next_state.irqMask);

		// bus answer: ack one cycle after the request, read data with it
		next_state.ack = busAccess && !state.ack;
		if (busAccess && !state.ack && !we_i) begin
			unique case (adr_i)
				break_pkg::OFS_BREAK_CONTROL: begin
					next_state.rdata = controlRead;
				end
				break_pkg::OFS_EXEC_COUNT: begin
					next_state.rdata = {20'h00000, execCount};
				end
				break_pkg::OFS_ASID_COMPARE_A: begin
					next_state.rdata = {24'h000000, state.asidCompareChanA};
				end
				break_pkg::OFS_ASID_COMPARE_B: begin
					next_state.rdata = {24'h000000, state.asidCompareChanB};
				end
				break_pkg::OFS_IRQ_STATUS: begin
					next_state.rdata = {27'h0000000, state.irqStatus};
				end
				break_pkg::OFS_IRQ_MASK: begin
					next_state.rdata = {27'h0000000, state.irqMask};
				end
				default: begin
					next_state.rdata = break_pkg::READ_UNMAPPED;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			state.ack <= 1'b0;
			state.rdata <= 32'h0000_0000;
			state.irq <= 1'b0;
			state.userBreak <= 1'b0;
			state.breakAfterExec <= 1'b0;
			state.asidMaskChanA <= break_pkg::RESET_CONTROL_BIT;
			state.asidMaskChanB <= break_pkg::RESET_CONTROL_BIT;
			state.lbusMatchFlagA <= break_pkg::RESET_CONTROL_BIT;
			state.lbusMatchFlagB <= break_pkg::RESET_CONTROL_BIT;
			state.ibusMatchFlagA <= break_pkg::RESET_CONTROL_BIT;
			state.ibusMatchFlagB <= break_pkg::RESET_CONTROL_BIT;
			state.branchTraceEnable <= break_pkg::RESET_CONTROL_BIT;
			state.fetchBreakAfterA <= break_pkg::RESET_CONTROL_BIT;
			state.fetchBreakAfterB <= break_pkg::RESET_CONTROL_BIT;
			state.dataCompareEnableB <= break_pkg::RESET_CONTROL_BIT;
			state.sequentialChannels <= break_pkg::RESET_CONTROL_BIT;
			state.execCountEnableB <= break_pkg::RESET_CONTROL_BIT;
			state.asidCompareChanA <= break_pkg::RESET_ASID_COMPARE;
			state.asidCompareChanB <= break_pkg::RESET_ASID_COMPARE;
			state.sequenceArmed <= 1'b0;
			state.pendingAfterA <= 1'b0;
			state.pendingAfterB <= 1'b0;
			state.irqStatus <= break_pkg::RESET_IRQ;
			state.irqMask <= break_pkg::RESET_IRQ;
		end else begin
			state <= next_state;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign dat_o = state.rdata;
	assign ack_o = state.ack;
	assign irq = state.irq;
	assign userBreak = state.userBreak;
	assign breakAfterExec = state.breakAfterExec;
	assign branchTraceEnable = state.branchTraceEnable;

endmodule // break_control_unit

// [test/break_control_unit_chk.sv]
module break_control_unit_chk (
	input wire logic clk,
	input wire logic rst,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [31:0] dat_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_o,
	input wire logic ack_o,
	input wire logic conditionHitA,
	input wire logic fetchCycle,
	input wire logic instrDone,
	input wire logic userBreak,
	input wire logic breakAfterExec,
	input wire logic branchTraceEnable,
	input wire logic irq
);
	timeunit 1ns;
	timeprecision 1ns;
	// ------
	// shadow of mask a, trace, after a, sequential
	// ------
	logic [3:0] ctl;
	logic wrCtl;
	logic irqAck;
	assign wrCtl = cyc_i && stb_i && we_i && ack_o && adr_i == 8'h00;
	assign irqAck = ack_o && (adr_i == 8'h10 || adr_i == 8'h14);
	always_ff @(posedge clk) begin
		if (rst) begin
			ctl <= 4'h0;
		end else if (wrCtl) begin
			if (sel_i[2]) ctl[3] <= dat_i[21];
			if (sel_i[1]) ctl[2:1] <= dat_i[11:10];
			if (sel_i[0]) ctl[0] <= dat_i[3];
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	chk_ack_next: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
		else $error("ack missing");
	chk_ack_single: assert property (ack_o |=> !ack_o)
		else $error("ack held");
	chk_rsv_zero: assert property (ack_o && !we_i && adr_i == 8'h00 |->
		dat_o[31:22] == 10'h000 && dat_o[19:16] == 4'h0) else $error("reserved bits set");
	chk_unmapped_zero: assert property (ack_o && !we_i && adr_i == 8'h18 |-> dat_o == 32'h0)
		else $error("unmapped read not zero");
	chk_trace_follow: assert property (wrCtl |-> ##2 branchTraceEnable == ctl[2])
		else $error("trace enable wrong");
	chk_break_a: assert property (conditionHitA && ctl[3] && !ctl[0]
		&& !(fetchCycle && ctl[1]) |=> userBreak && !breakAfterExec) else $error("no break a");
	chk_after_cause: assert property (userBreak && breakAfterExec |-> $past(instrDone))
		else $error("after break without done");
	chk_irq_drop: assert property ($fell(irq) |-> irqAck || $past(irqAck))
		else $error("irq fell unprompted");
	cover property (userBreak && breakAfterExec);
	cover property (irq);
	cover property (wrCtl);
endmodule // break_control_unit_chk
bind break_control_unit break_control_unit_chk break_control_unit_chk_i (.clk(clk), .rst(rst),
	.cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i),
	.dat_o(dat_o), .ack_o(ack_o), .conditionHitA(conditionHitA), .fetchCycle(fetchCycle),
	.instrDone(instrDone), .userBreak(userBreak), .breakAfterExec(breakAfterExec),
	.branchTraceEnable(branchTraceEnable), .irq(irq));

// [test/core_bus_model.sv]
module core_bus_model (
	input wire logic clk,
	input wire logic [15:0] cmd,
	output logic conditionHitA,
	output logic conditionHitB,
	output logic lbusCycle,
	output logic ibusCycle,
	output logic fetchCycle,
	output logic dataHitB,
	output logic instrDone,
	output logic [7:0] currentAsid
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		{instrDone, dataHitB, fetchCycle, ibusCycle, lbusCycle, conditionHitB, conditionHitA} = 7'h0;
		currentAsid = 8'ha5;
	end
	// one bus cycle per command; idle cycles wander the identifier
	always @(posedge clk) begin
		{instrDone, dataHitB, fetchCycle, ibusCycle, lbusCycle, conditionHitB, conditionHitA}
			<= cmd[6:0];
		currentAsid <= (cmd[6:0] == 7'h0) ? ~currentAsid : cmd[15:8];
	end
endmodule // core_bus_model

// [test/tb.sv]
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic cyc, stb, we, ack, hA, hB, lb, ib, fe, dB, dn, ub, bae, bte, irq;
	logic [7:0] adr, asid;
	logic [31:0] dw, dr, r, x;
	logic [3:0] sel;
	logic [15:0] cmd;
	int ctl, asA, asB, cnt, st, mk, armed, fail_count, n_compared;
	int expQ[$];
	logic obsQ[$];
	always #50 clk = ~clk;
	core_bus_model core_bus_model_i (.clk(clk), .cmd(cmd), .conditionHitA(hA),
		.conditionHitB(hB), .lbusCycle(lb), .ibusCycle(ib), .fetchCycle(fe), .dataHitB(dB),
		.instrDone(dn), .currentAsid(asid));
	break_control_unit break_control_unit_i (.clk(clk), .rst(rst), .cyc_i(cyc), .stb_i(stb),
		.we_i(we), .adr_i(adr), .dat_i(dw), .sel_i(sel), .dat_o(dr), .ack_o(ack),
		.lbusCycle(lb), .ibusCycle(ib), .fetchCycle(fe), .currentAsid(asid), .conditionHitA(hA),
		.conditionHitB(hB), .dataHitB(dB), .instrDone(dn), .userBreak(ub),
		.breakAfterExec(bae), .branchTraceEnable(bte), .irq(irq));
	always @(posedge clk) if (ub === 1'b1) obsQ.push_back(bae);
	// ------
	// checking and bus tasks
	// ------
	task automatic cmp(input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			fail_count++;
			$display("mismatch t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask
	task automatic cmpBit(input logic e, input logic g);
		cmp({31'h0, e}, {31'h0, g});
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		{cyc, stb, we, adr, dw} <= {2'b11, w, a, d};
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 50);
		r = dr;
		if (n >= 50) fail_count++;
		{cyc, stb} <= 2'b00;
		@(posedge clk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h0);
		cmp(e, r);
		if (a == 8'h10) st = 0;
	endtask
	task automatic wrc(input logic [31:0] d);
		ctl = (d & 32'h0030_0cc9) | (ctl & d & 32'hf000);
		if (!ctl[3]) armed = 0;
		wb(1'b1, 8'h00, d);
	endtask
	task automatic settle;
		repeat (3) @(posedge clk);
		cmp(expQ.size(), obsQ.size());
		while (expQ.size() > 0 && obsQ.size() > 0) cmpBit(expQ.pop_front(), obsQ.pop_front());
		expQ.delete();
		obsQ.delete();
		cmpBit((st & mk) != 0, irq);
	endtask
	task automatic ev(input logic a, b, l, f, d, input logic [7:0] s);
		logic hitA, hitB, cB, bA, bB, pre, post;
		hitA = a && (ctl[21] || s == asA);
		hitB = b && (ctl[20] || s == asB) && (!ctl[7] || d);
		cB = hitB && (!ctl[3] || armed);
		if (hitA) ctl |= l ? 32'h8000 : 32'h2000;
		if (hitA) st |= l ? 1 : 4;
		if (cB) ctl |= l ? 32'h4000 : 32'h1000;
		if (cB) st |= l ? 2 : 8;
		bA = hitA && !ctl[3];
		bB = cB && (!ctl[0] || cnt == 1);
		if (cB && ctl[0] && cnt > 0) cnt--;
		if (ctl[3] && hitA) armed = 1;
		else if (bB) armed = 0;
		// a before break and an after break in one cycle give two pulses
		pre = bA && !(f && ctl[10]) || bB && !(f && ctl[6]);
		post = bA && f && ctl[10] || bB && f && ctl[6];
		if (bA || bB) st |= 16;
		if (pre) expQ.push_back(1'b0);
		if (post) expQ.push_back(1'b1);
		cmd <= {s, 2'b00, d, f, !l, l, b, a};
		@(posedge clk);
		cmd <= 16'h0;
		repeat (3) @(posedge clk);
		cmd <= 16'h0040;
		@(posedge clk);
		cmd <= 16'h0;
		settle();
	endtask
	task automatic stop_test;
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	// ------
	// test sequence
	// ------
	initial begin
		{cyc, stb, we, adr, dw, sel, cmd} = '0;
		sel = 4'hf;
		{ctl, asA, asB, cnt, st, mk, armed, fail_count, n_compared} = '0;
		void'($urandom(62));
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		for (int a = 0; a <= 24; a += 4) rd(8'(a), 32'h0);
		wrc(32'h0030_fcc9);
		rd(8'h00, ctl);
		cmpBit(1'b1, bte);
		wrc(32'h0);
		cmpBit(1'b0, bte);
		asA = $urandom_range(255);
		asB = $urandom_range(255);
		wb(1'b1, 8'h08, asA);
		wb(1'b1, 8'h0c, asB);
		rd(8'h08, asA);
		rd(8'h0c, asB);
		for (int i = 0; i < 24; i++) begin
			x = $urandom;
			mk = x[28:24];
			wb(1'b1, 8'h14, mk);
			wrc(x & 32'h0030_04c0);
			ev(x[3], x[4], x[5], x[11], x[6], x[8] ? asA : (x[9] ? asB : x[23:16]));
			rd(8'h00, ctl);
			wrc(ctl | 32'hf000);
			rd(8'h00, ctl);
			rd(8'h10, st);
			cmpBit((st & mk) != 0, irq);
		end
		wrc(32'h0030_0008);
		ev(1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 8'h00);
		ev(1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 8'h00);
		ev(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 8'h00);
		wrc(32'h0030_0001);
		cnt = 3;
		wb(1'b1, 8'h04, 32'h3);
		for (int k = 0; k < 4; k++) begin
			ev(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 8'h00);
			rd(8'h04, cnt);
		end
		wrc(32'h0020_0000);
		ev(1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 8'h00);
		fork
			wb(1'b1, 8'h00, 32'h0020_0000);
			begin
				cmd <= 16'h0005;
				@(posedge clk);
				cmd <= 16'h0;
			end
		join
		expQ.push_back(0);
		st |= 17;
		settle();
		rd(8'h00, 32'h0020_8000);
		stop_test();
	end
	// whole run is well under 20000 cycles
	initial begin
		#(30000 * 100);
		fail_count++;
		stop_test();
	end
endmodule // tb
